// file: hw/fbap_host.sv
// Summary of operation
// - host does not reissue the sequence after abort; software must
// - host writes read-array after each erase and program
// - write only with select and strobe low
// - host keeps reset pin high during operations
// - host waits wake-up intervals after reset
// - read-array command byte is FFH
// - block erase is 20H then D0H
`default_nettype none
module fbap_host
	import fbap_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output var  logic [31:0] prdata_out,
	output var  logic        pready_out,
	output var  logic        pslverr_out,
	// flash device pins
	input  wire logic        operation_done_in,
	input  wire logic [7:0]  flash_data_in,
	output var  fbap_pins_t  flash_out
);

	fbap_state_t      state_reg,      state_next;
	fbap_op_t         op_reg,         op_next;
	logic [2:0]       phase_reg,      phase_next;
	fbap_pins_t       pins_reg,       pins_next;
	logic [19:0]      addr_reg,       addr_next;
	logic [7:0]       wdata_reg,      wdata_next;
	logic [7:0]       rdata_reg,      rdata_next;
	logic [7:0]       sbyte_reg,      sbyte_next;
	logic             busy_reg,       busy_next;
	logic             aborted_reg,    aborted_next;
	logic             pd_reg,         pd_next;
	logic             refused_reg,    refused_next;
	logic             done_pin_reg,   done_pin_next;
	logic [31:0]      prdata_reg,     prdata_next;
	logic             pready_reg,     pready_next;
	logic             pslverr_reg,    pslverr_next;
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_count;
	logic             tmr_expired;
	logic             apb_fire;
	logic             go;
	fbap_op_t         go_op;
	fbap_act_t        act;
	logic [31:0]      status_word;
	logic             mapped;

	fbap_timer u_timer (
		.clk_sys_in  (clk_sys_in),
		.rst_in      (rst_in),
		.load_in     (tmr_load),
		.count_in    (tmr_count),
		.expired_out (tmr_expired)
	);

	// the write acts at the edge where the master sees pready high
	assign apb_fire = psel_in && penable_in && pready_reg;
	assign go       = apb_fire && pwrite_in && (paddr_in == REG_CTRL);
	assign go_op    = fbap_op_t'(pwdata_in[2:0]);
	assign act      = fbap_step_action(op_reg, phase_reg);
	assign mapped   = (paddr_in == REG_CTRL) || (paddr_in == REG_ADDR) || (paddr_in == REG_WDATA)
		|| (paddr_in == REG_STATUS) || (paddr_in == REG_RDATA);

	always_comb begin
		status_word = WORD_ZERO;
		status_word[ST_BUSY]                  = busy_reg;
		status_word[ST_DONE_PIN]              = done_pin_reg;
		status_word[ST_ABORTED]               = aborted_reg;
		status_word[ST_PD]                    = pd_reg;
		status_word[ST_REFUSED]               = refused_reg;
		status_word[ST_BYTE_LSB +: 8]         = sbyte_reg;
		status_word[ST_READY]                 = sbyte_reg[SR_READY_BIT];
		status_word[ST_SUPPLY]                = sbyte_reg[SR_SUPPLY_BIT];
		status_word[ST_PROG_ERR]              = sbyte_reg[SR_PROG_ERR_BIT];
		status_word[ST_ERASE_ERR]             = sbyte_reg[SR_ERASE_ERR_BIT];
	end

	// apb register file
	always_comb begin
		addr_next    = addr_reg;
		wdata_next   = wdata_reg;
		pready_next  = psel_in && penable_in && !pready_reg;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		if (psel_in && penable_in && !pready_reg) begin
			pslverr_next = !mapped;
			unique case (1'b1)
				paddr_in == REG_ADDR:   prdata_next = {12'h000, addr_reg};
				paddr_in == REG_WDATA:  prdata_next = {24'h00_0000, wdata_reg};
				paddr_in == REG_STATUS: prdata_next = status_word;
				paddr_in == REG_RDATA:  prdata_next = {24'h00_0000, rdata_reg};
				default:                prdata_next = WORD_ZERO;
			endcase
		end
		if (apb_fire && pwrite_in && paddr_in == REG_ADDR)
			addr_next = pwdata_in[19:0];
		if (apb_fire && pwrite_in && paddr_in == REG_WDATA)
			wdata_next = pwdata_in[7:0];
	end

	// sequencer
	always_comb begin
		state_next    = state_reg;
		op_next       = op_reg;
		phase_next    = phase_reg;
		pins_next     = pins_reg;
		rdata_next    = rdata_reg;
		sbyte_next    = sbyte_reg;
		busy_next     = busy_reg;
		aborted_next  = aborted_reg;
		pd_next       = pd_reg;
		refused_next  = refused_reg;
		done_pin_next = operation_done_in;
		tmr_load      = 1'b0;
		tmr_count     = '0;
		// sticky flags clear on write of one; a same-cycle event still wins
		if (apb_fire && pwrite_in && paddr_in == REG_STATUS) begin
			if (pwdata_in[ST_ABORTED])
				aborted_next = 1'b0;
			if (pwdata_in[ST_REFUSED])
				refused_next = 1'b0;
		end
		unique case (state_reg)
			S_IDLE: begin
				if (go) begin
					if (go_op == OP_SLEEP) begin
						pins_next.rp_n = 1'b0;
						tmr_load       = 1'b1;
						tmr_count      = RP_LOW_CYC - TMR_ONE;
						busy_next      = 1'b1;
						state_next     = S_RST_LOW;
					end else if (go_op == OP_READ || go_op == OP_ERASE || go_op == OP_PROGRAM
						|| go_op == OP_CLEAR) begin
						op_next    = go_op;
						phase_next = PH_ZERO;
						busy_next  = 1'b1;
						state_next = S_STEP;
					end else begin
						refused_next = 1'b1;
					end
				end
			end
			S_STEP: begin
				unique case (act)
					ACT_WRITE: begin
						pins_next.ce_n = 1'b0;
						pins_next.addr = addr_reg;
						pins_next.dout = fbap_step_data(op_reg, phase_reg, wdata_reg);
						pins_next.doe  = 1'b1;
						state_next     = S_WR_SET;
					end
					ACT_READ: begin
						pins_next.ce_n = 1'b0;
						pins_next.oe_n = 1'b0;
						pins_next.addr = addr_reg;
						tmr_load       = 1'b1;
						tmr_count      = RD_ACC_CYC - TMR_ONE;
						state_next     = S_RD;
					end
					ACT_WAIT: begin
						// done pin may take a while to fall after the confirm or data write
						tmr_load   = 1'b1;
						tmr_count  = BUSY_DLY_CYC;
						state_next = S_WAIT;
					end
					ACT_END: begin
						busy_next  = 1'b0;
						state_next = S_IDLE;
					end
				endcase
			end
			S_WR_SET: begin
				pins_next.we_n = 1'b0;
				tmr_load       = 1'b1;
				tmr_count      = WE_LOW_CYC - TMR_ONE;
				state_next     = S_WR_LOW;
			end
			S_WR_LOW: begin
				if (tmr_expired) begin
					pins_next.we_n = 1'b1;
					state_next     = S_WR_END;
				end
			end
			S_WR_END: begin
				pins_next.ce_n = 1'b1;
				pins_next.doe  = 1'b0;
				phase_next     = phase_reg + PH_ONE;
				state_next     = S_STEP;
			end
			S_RD: begin
				if (tmr_expired) begin
					if (op_reg == OP_READ)
						rdata_next = flash_data_in;
					else
						sbyte_next = flash_data_in;
					pins_next.ce_n = 1'b1;
					pins_next.oe_n = 1'b1;
					phase_next     = phase_reg + PH_ONE;
					state_next     = S_STEP;
				end
			end
			S_WAIT: begin
				if (tmr_expired && operation_done_in) begin
					phase_next = phase_reg + PH_ONE;
					state_next = S_STEP;
				end
			end
			S_RST_LOW: begin
				if (tmr_expired) begin
					pd_next    = 1'b1;
					sbyte_next = BYTE_RST;
					busy_next  = 1'b0;
					state_next = S_PD;
				end
			end
			S_PD: begin
				if (go) begin
					if (go_op == OP_WAKE) begin
						pins_next.rp_n = 1'b1;
						tmr_load       = 1'b1;
						tmr_count      = WAKE_WR_CYC - TMR_ONE;
						busy_next      = 1'b1;
						state_next     = S_WAKE;
					end else begin
						refused_next = 1'b1;
					end
				end
			end
			S_WAKE: begin
				if (tmr_expired) begin
					pd_next    = 1'b0;
					busy_next  = 1'b0;
					state_next = S_IDLE;
				end
			end
			default: begin
				pins_next  = PINS_IDLE;
				busy_next  = 1'b0;
				state_next = S_IDLE;
			end
		endcase
		// abort: drop the reset pin; the operation is lost and must be reissued
		if (go && go_op == OP_ABORT && busy_reg && state_reg != S_RST_LOW && state_reg != S_WAKE) begin
			pins_next      = PINS_IDLE;
			pins_next.rp_n = 1'b0;
			aborted_next   = 1'b1;
			tmr_load       = 1'b1;
			tmr_count      = RP_LOW_CYC - TMR_ONE;
			state_next     = S_RST_LOW;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg    <= S_IDLE;
			op_reg       <= OP_NONE;
			phase_reg    <= PH_ZERO;
			pins_reg     <= PINS_IDLE;
			addr_reg     <= ADDR_RST;
			wdata_reg    <= BYTE_RST;
			rdata_reg    <= BYTE_RST;
			sbyte_reg    <= BYTE_RST;
			busy_reg     <= 1'b0;
			aborted_reg  <= 1'b0;
			pd_reg       <= 1'b0;
			refused_reg  <= 1'b0;
			done_pin_reg <= 1'b0;
			prdata_reg   <= WORD_ZERO;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
		end else begin
			state_reg    <= state_next;
			op_reg       <= op_next;
			phase_reg    <= phase_next;
			pins_reg     <= pins_next;
			addr_reg     <= addr_next;
			wdata_reg    <= wdata_next;
			rdata_reg    <= rdata_next;
			sbyte_reg    <= sbyte_next;
			busy_reg     <= busy_next;
			aborted_reg  <= aborted_next;
			pd_reg       <= pd_next;
			refused_reg  <= refused_next;
			done_pin_reg <= done_pin_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
		end
	end

	assign prdata_out  = prdata_reg;
	assign pready_out  = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign flash_out   = pins_reg;

	// helper state watched only by the checks below
	logic [TMR_W-1:0] since_rp_reg;
	logic [7:0]       last_wr_reg;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			since_rp_reg <= TMR_SAT;
			last_wr_reg  <= BYTE_RST;
		end else begin
			if (!pins_reg.rp_n)
				since_rp_reg <= '0;
			else if (since_rp_reg != TMR_SAT)
				since_rp_reg <= since_rp_reg + TMR_ONE;
			if (pins_reg.we_n == 1'b0 && pins_next.we_n == 1'b1)
				last_wr_reg <= pins_reg.dout;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence we_pulse_s;
		$fell(pins_reg.we_n) ##0 (!pins_reg.we_n)[*2] ##1 pins_reg.we_n;
	endsequence
	sequence confirm_write_s;
		$fell(pins_reg.we_n) && pins_reg.dout == CMD_CONFIRM && op_reg == OP_ERASE;
	endsequence

	AST_WE_NEEDS_CE: assert property (!pins_reg.we_n |-> !pins_reg.ce_n && pins_reg.doe)
		else $error("write strobe low without chip select");
	AST_WE_WIDTH: assert property ($fell(pins_reg.we_n) |-> we_pulse_s)
		else $error("write strobe pulse width wrong");
	AST_RP_HIGH_IN_OP: assert property (!pins_reg.rp_n |-> state_reg == S_RST_LOW || state_reg == S_PD)
		else $error("reset pin low during operation");
	AST_WAKE_WRITE: assert property ($fell(pins_reg.we_n) |-> since_rp_reg >= WAKE_WR_CYC)
		else $error("write too soon after wake");
	AST_WAKE_READ: assert property ($fell(pins_reg.oe_n) |-> since_rp_reg >= WAKE_RD_CYC)
		else $error("read too soon after wake");
	AST_ERASE_PAIR: assert property (confirm_write_s |-> last_wr_reg == CMD_ERASE_SETUP)
		else $error("erase confirm without setup");
	AST_FINAL_ARRAY: assert property (state_reg == S_STEP && act == ACT_END
		&& (op_reg == OP_ERASE || op_reg == OP_PROGRAM) |-> last_wr_reg == CMD_READ_ARRAY)
		else $error("operation ended without read-array write");
	AST_ABORT_PD: assert property ($rose(aborted_reg) |-> ##[1:8] (pd_reg && !busy_reg))
		else $error("abort did not reach power-down");
	AST_NO_SILENT_RETRY: assert property ($past(state_reg) == S_PD |-> state_reg != S_STEP)
		else $error("operation resumed without new command");

endmodule : fbap_host
`default_nettype wire

// file: hw/fbap_pkg.sv
`default_nettype none
package fbap_pkg;

	localparam int CLK_MHZ = 25;

	// least times, rounded up to whole cycles of clk_sys_in
	function automatic int fbap_ns_to_cyc(input int ns);
		int cyc;
		cyc = (ns * CLK_MHZ + 999) / 1000;
		return (cyc < 1) ? 1 : cyc;
	endfunction : fbap_ns_to_cyc

	localparam int TMR_W = 6;

	localparam int WE_LOW_NS   = 70;
	localparam int RD_ACC_NS   = 170;
	localparam int BUSY_DLY_NS = 100;
	localparam int RP_LOW_NS   = 100;
	localparam int WAKE_RD_NS  = 600;
	localparam int WAKE_WR_NS  = 1000;

	localparam logic [TMR_W-1:0] WE_LOW_CYC   = TMR_W'(fbap_ns_to_cyc(WE_LOW_NS));
	localparam logic [TMR_W-1:0] RD_ACC_CYC   = TMR_W'(fbap_ns_to_cyc(RD_ACC_NS));
	localparam logic [TMR_W-1:0] BUSY_DLY_CYC = TMR_W'(fbap_ns_to_cyc(BUSY_DLY_NS));
	localparam logic [TMR_W-1:0] RP_LOW_CYC   = TMR_W'(fbap_ns_to_cyc(RP_LOW_NS));
	localparam logic [TMR_W-1:0] WAKE_RD_CYC  = TMR_W'(fbap_ns_to_cyc(WAKE_RD_NS));
	localparam logic [TMR_W-1:0] WAKE_WR_CYC  = TMR_W'(fbap_ns_to_cyc(WAKE_WR_NS));
	localparam logic [TMR_W-1:0] TMR_ONE      = 6'h01;
	localparam logic [TMR_W-1:0] TMR_SAT      = 6'h3F;

	// software register map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;

	localparam int ST_BUSY      = 0;
	localparam int ST_DONE_PIN  = 1;
	localparam int ST_ABORTED   = 2;
	localparam int ST_PD        = 3;
	localparam int ST_REFUSED   = 4;
	localparam int ST_BYTE_LSB  = 8;
	localparam int ST_READY     = 16;
	localparam int ST_SUPPLY    = 17;
	localparam int ST_PROG_ERR  = 18;
	localparam int ST_ERASE_ERR = 19;

	// bit positions in the device status byte
	localparam int SR_READY_BIT     = 7;
	localparam int SR_ERASE_ERR_BIT = 5;
	localparam int SR_PROG_ERR_BIT  = 4;
	localparam int SR_SUPPLY_BIT    = 3;

	localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
	localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

	localparam logic [19:0] ADDR_RST  = 20'h0_0000;
	localparam logic [7:0]  BYTE_RST  = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	localparam logic [2:0] PH_ZERO  = 3'h0;
	localparam logic [2:0] PH_ONE   = 3'h1;
	localparam logic [2:0] PH_WAIT  = 3'h2;
	localparam logic [2:0] PH_STAT  = 3'h3;
	localparam logic [2:0] PH_FINAL = 3'h4;

	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_READ    = 3'b001,
		OP_ERASE   = 3'b010,
		OP_PROGRAM = 3'b011,
		OP_CLEAR   = 3'b100,
		OP_SLEEP   = 3'b101,
		OP_WAKE    = 3'b110,
		OP_ABORT   = 3'b111
	} fbap_op_t;

	typedef enum logic [1:0] {
		ACT_WRITE = 2'b00,
		ACT_READ  = 2'b01,
		ACT_WAIT  = 2'b10,
		ACT_END   = 2'b11
	} fbap_act_t;

	typedef enum logic [3:0] {
		S_IDLE    = 4'b0000,
		S_STEP    = 4'b0001,
		S_WR_SET  = 4'b0010,
		S_WR_LOW  = 4'b0011,
		S_WR_END  = 4'b0100,
		S_RD      = 4'b0101,
		S_WAIT    = 4'b0110,
		S_RST_LOW = 4'b0111,
		S_PD      = 4'b1000,
		S_WAKE    = 4'b1001
	} fbap_state_t;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        rp_n;
		logic [19:0] addr;
		logic [7:0]  dout;
		logic        doe;
	} fbap_pins_t;

	localparam fbap_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b1,
		addr: ADDR_RST, dout: BYTE_RST, doe: 1'b0};

	// command script: erase/program = setup, confirm or data byte, wait, status read, read-array
	function automatic fbap_act_t fbap_step_action(input fbap_op_t op, input logic [2:0] ph);
		fbap_act_t act;
		act = ACT_END;
		case (op)
			OP_ERASE, OP_PROGRAM: begin
				if (ph == PH_ZERO || ph == PH_ONE || ph == PH_FINAL)
					act = ACT_WRITE;
				else if (ph == PH_WAIT)
					act = ACT_WAIT;
				else if (ph == PH_STAT)
					act = ACT_READ;
			end
			OP_READ: begin
				if (ph == PH_ZERO)
					act = ACT_WRITE;
				else if (ph == PH_ONE)
					act = ACT_READ;
			end
			OP_CLEAR: begin
				if (ph == PH_ZERO)
					act = ACT_WRITE;
			end
			default: act = ACT_END;
		endcase
		return act;
	endfunction : fbap_step_action

	function automatic logic [7:0] fbap_step_data(input fbap_op_t op, input logic [2:0] ph,
		input logic [7:0] wdata);
		logic [7:0] d;
		d = CMD_READ_ARRAY;
		if (op == OP_CLEAR)
			d = CMD_CLEAR_STATUS;
		else if (op == OP_ERASE && ph == PH_ZERO)
			d = CMD_ERASE_SETUP;
		else if (op == OP_ERASE && ph == PH_ONE)
			d = CMD_CONFIRM;
		else if (op == OP_PROGRAM && ph == PH_ZERO)
			d = CMD_PROG_SETUP;
		else if (op == OP_PROGRAM && ph == PH_ONE)
			d = wdata;
		return d;
	endfunction : fbap_step_data

endpackage : fbap_pkg
`default_nettype wire

// file: hw/fbap_timer.sv
`default_nettype none
module fbap_timer
	import fbap_pkg::*;
(
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	// control
	input  wire logic             load_in,
	input  wire logic [TMR_W-1:0] count_in,
	// status
	output wire logic             expired_out
);

	logic [TMR_W-1:0] cnt_reg;
	logic [TMR_W-1:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (load_in)
			cnt_next = count_in;
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - TMR_ONE;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign expired_out = (cnt_reg == '0) && !load_in;

endmodule : fbap_timer
`default_nettype wire

// file: tb/fbap_flash_model.sv
`default_nettype none
module fbap_flash_model
	import fbap_pkg::*;
(
	// host pins
	input  wire logic       clk_sys_in,
	input  wire fbap_pins_t pins_in,
	output wire logic       done_out,
	output var  logic [7:0] data_out,
	// fault and pacing from the bench
	input  wire logic       supply_low_in,
	input  wire logic [7:0] busy_cyc_in
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] RST_CYC = 8'h04;
	logic [7:0] mem [256];
	logic [7:0] sr        = 8'h00;
	logic [7:0] last_cmd  = 8'hFF;
	logic [7:0] busy_cnt  = 8'h00;
	logic [7:0] rst_cnt   = 8'h00;
	logic [7:0] drv_q     = 8'h00;
	logic [5:0] wake_cnt  = 6'h3F;
	logic       we_q      = 1'b1;
	logic       rp_q      = 1'b1;
	logic       set_er    = 1'b0;
	logic       set_pg    = 1'b0;
	logic       stat_mode = 1'b0;
	logic       wake_err  = 1'b0;
	logic [7:0] d;
	logic [7:0] a;
	assign d = pins_in.dout;
	assign a = pins_in.addr[7:0];
	initial foreach (mem[i]) mem[i] = 8'h00;
	assign done_out = (busy_cnt == 8'h00) && (rst_cnt == 8'h00);
	// released bus shows a changing pattern, never the byte of the cycle before
	always_comb begin
		if (!pins_in.ce_n && !pins_in.oe_n && pins_in.rp_n)
			data_out = stat_mode ? {done_out, sr[6:0]} : mem[a];
		else
			data_out = ~drv_q;
	end
	always @(posedge clk_sys_in) begin
		we_q  <= pins_in.we_n;
		rp_q  <= pins_in.rp_n;
		drv_q <= data_out;
		if (rst_cnt != 8'h00)
			rst_cnt <= rst_cnt - 8'h01;
		if (busy_cnt != 8'h00)
			busy_cnt <= busy_cnt - 8'h01;
		if (wake_cnt != 6'h3F)
			wake_cnt <= wake_cnt + 6'h01;
		if (!pins_in.rp_n) begin
			sr        <= 8'h00;
			stat_mode <= 1'b0;
			set_er    <= 1'b0;
			set_pg    <= 1'b0;
			wake_cnt  <= 6'h00;
			busy_cnt  <= 8'h00;
			if (rp_q && busy_cnt != 8'h00)
				rst_cnt <= RST_CYC;
		end else begin
			if ((!pins_in.we_n && wake_cnt < WAKE_WR_CYC) || (!pins_in.oe_n && wake_cnt < WAKE_RD_CYC))
				wake_err <= 1'b1;
			if (!we_q && pins_in.we_n && !pins_in.ce_n && busy_cnt == 8'h00) begin
				last_cmd  <= d;
				stat_mode <= (d != CMD_READ_ARRAY);
				set_er    <= (d == CMD_ERASE_SETUP) && !set_pg;
				set_pg    <= (d == CMD_PROG_SETUP) && !set_pg;
				if (d == CMD_CLEAR_STATUS)
					sr <= 8'h00;
				if ((set_er && d == CMD_CONFIRM) || set_pg) begin
					busy_cnt <= busy_cyc_in;
					sr[3]    <= sr[3] | supply_low_in;
					sr[4]    <= sr[4] | (set_pg & supply_low_in);
					sr[5]    <= sr[5] | (!set_pg & supply_low_in);
				end
				if (set_er && d == CMD_CONFIRM && !supply_low_in)
					foreach (mem[i]) mem[i] <= 8'hFF;
				if (set_pg && !supply_low_in)
					mem[a] <= mem[a] & d;
			end
		end
	end
endmodule : fbap_flash_model
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench
	import fbap_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        done;
	logic [7:0]  fdata;
	fbap_pins_t  pins;
	logic        supply_low = 1'b0;
	logic [7:0]  busy_cyc   = 8'h28;
	logic [31:0] rdq;
	logic        errq;
	int          error_cnt  = 0;
	int          checks     = 0;
	int          cyc        = 0;

	always #20 clk_sys_in = ~clk_sys_in;

	fbap_host uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .operation_done_in(done),
		.flash_data_in(fdata), .flash_out(pins));
	fbap_flash_model flash (.clk_sys_in(clk_sys_in), .pins_in(pins), .done_out(done),
		.data_out(fdata), .supply_low_in(supply_low), .busy_cyc_in(busy_cyc));

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	// a hang counts as a mismatch
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// idle edge at the end keeps back-to-back calls from double-driving psel
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do
			@(posedge clk_sys_in);
		while (pready !== 1'b1);
		rdq = prdata;
		errq = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_in);
	endtask : apb

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0000_0000);
			n++;
		end while (rdq[ST_BUSY] !== 1'b0 && n < 300);
		check(n < 300, 1'b1);
	endtask : wait_idle

	task automatic run_op(input fbap_op_t op);
		apb(1'b1, REG_CTRL, 32'(op));
		wait_idle();
	endtask : run_op

	task automatic wait_pin(input logic lvl);
		for (int n = 0; n < 100 && done !== lvl; n++)
			@(posedge clk_sys_in);
		check(done, lvl);
	endtask : wait_pin

	task automatic t_reset();
		check(pins, PINS_IDLE);
		apb(1'b0, 8'h20, 32'h0000_0000);
		check({errq, rdq}, 33'h1_0000_0000);
		apb(1'b1, REG_ADDR, 32'h000F_FFFF);
		apb(1'b0, REG_ADDR, 32'h0000_0000);
		check({errq, rdq}, 33'h0_000F_FFFF);
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		check(rdq[ST_DONE_PIN:ST_BUSY], 2'b10);
		$display("test reset finished");
	endtask : t_reset

	task automatic t_erase();
		apb(1'b1, REG_ADDR, 32'h0000_0010);
		apb(1'b1, REG_CTRL, 32'(OP_ERASE));
		wait_pin(1'b0);
		check(flash.last_cmd, CMD_CONFIRM);
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		check(rdq[ST_DONE_PIN:ST_BUSY], 2'b01);
		wait_idle();
		check(rdq[ST_ERASE_ERR:ST_READY], 4'h1);
		check(flash.last_cmd, CMD_READ_ARRAY);
		check(flash.mem[16], 8'hFF);
		$display("test erase finished");
	endtask : t_erase

	task automatic t_fault();
		supply_low <= 1'b1;
		apb(1'b1, REG_WDATA, 32'h0000_005A);
		for (int k = 0; k < 2; k++) begin
			run_op(k ? OP_ERASE : OP_PROGRAM);
			check(rdq[ST_ERASE_ERR:ST_SUPPLY], k ? 3'b101 : 3'b011);
			run_op(OP_CLEAR);
		end
		supply_low <= 1'b0;
		run_op(OP_PROGRAM);
		check(rdq[ST_ERASE_ERR:ST_SUPPLY], 3'b000);
		run_op(OP_READ);
		apb(1'b0, REG_RDATA, 32'h0000_0000);
		check(rdq[7:0], 8'h5A);
		$display("test fault finished");
	endtask : t_fault

	// idle refusal of an empty order, then a plain sleep and wake with no operation running
	task automatic t_sleep();
		apb(1'b1, REG_CTRL, 32'(OP_NONE));
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		check({rdq[ST_REFUSED], rdq[ST_BUSY]}, 2'b10);
		apb(1'b1, REG_STATUS, 32'h0000_0010);
		run_op(OP_SLEEP);
		check({rdq[ST_PD], rdq[ST_REFUSED], pins.rp_n, done}, 4'b1001);
		check(flash.last_cmd, CMD_READ_ARRAY);
		run_op(OP_WAKE);
		check({rdq[ST_PD], pins.rp_n, flash.stat_mode}, 3'b010);
		$display("test sleep finished");
	endtask : t_sleep

	task automatic t_abort();
		busy_cyc <= 8'hC8;
		apb(1'b1, REG_CTRL, 32'(OP_PROGRAM));
		wait_pin(1'b0);
		apb(1'b1, REG_CTRL, 32'(OP_ABORT));
		for (int n = 0; n < 20 && pins.rp_n !== 1'b0; n++)
			@(posedge clk_sys_in);
		repeat (2) @(posedge clk_sys_in);
		check(done, 1'b0);
		repeat (8) @(posedge clk_sys_in);
		check(done, 1'b1);
		check(flash.sr, 8'h00);
		wait_idle();
		check({rdq[ST_PD], rdq[ST_ABORTED]}, 2'b11);
		apb(1'b1, REG_CTRL, 32'(OP_ERASE));
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		check({rdq[ST_REFUSED], pins.rp_n}, 2'b10);
		apb(1'b1, REG_STATUS, 32'h0000_0014);
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		check({rdq[ST_REFUSED], rdq[ST_ABORTED]}, 2'b00);
		busy_cyc <= 8'h10;
		run_op(OP_WAKE);
		check({rdq[ST_PD], flash.stat_mode}, 2'b00);
		run_op(OP_PROGRAM);
		check(rdq[ST_ERASE_ERR:ST_READY], 4'h1);
		check(flash.wake_err, 1'b0);
		$display("test abort finished");
	endtask : t_abort

	initial begin
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		t_reset();
		t_erase();
		t_fault();
		t_sleep();
		t_abort();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
